// [cfg_port_pkg.sv]
// constants and carrier types for the three-wire configuration port host
// assumes a single 8-bit register bank behind a select/clock/data link
package cfg_port_pkg;
    localparam int          ADDR_W       = 7;
    localparam int          OCT_W        = 8;
    localparam int          LEN_W        = 5;
    localparam int          BANK_REGS    = 23;
    localparam int          WR_REGS      = 22;
    localparam logic [6:0]  LAST_WR_ADDR = 7'h15;
    localparam logic [6:0]  LAST_RD_ADDR = 7'h16;
    localparam logic        FLAG_READ    = 1'h1;
    localparam logic        FLAG_WRITE   = 1'h0;
    localparam int          CLK_HZ       = 100_000_000;
    localparam int          SCLK_DIV     = 4;
    localparam int          POR_NS       = 10_000;
    localparam int          POR_CYC      = (POR_NS + 9) / 10;

    typedef struct packed {
        logic                read;
        logic [ADDR_W-1:0]   addr;
        logic [LEN_W-1:0]    count;
    } cmd_t;

    typedef struct packed {
        logic [ADDR_W-1:0]   addr;
        logic [OCT_W-1:0]    data;
    } rd_word_t;
endpackage

// [cfg_port_host.sv]
// host end of the three-wire configuration port
// assumes write octets come on a valid/ready stream and read octets leave
// through a two-entry buffer; link logic runs on link_clock
`timescale 1ns/10ps
module cfg_port_host #(
    parameter int POR_CYCLES = cfg_port_pkg::POR_CYC
) (
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire logic                  link_clock,
    input  wire logic                  link_rst,
    input  wire cfg_port_pkg::cmd_t    cmd,
    input  wire logic                  cmd_valid,
    output logic                       cmd_ready,
    input  wire logic [7:0]            wr_data,
    input  wire logic                  wr_valid,
    output logic                       wr_ready,
    output cfg_port_pkg::rd_word_t     rd_word,
    output logic                       rd_valid,
    input  wire logic                  rd_ready,
    output logic                       busy,
    output logic                       cs,
    output logic                       sclk,
    output logic                       sdio_o,
    output logic                       sdio_oe,
    input  wire logic                  sdio_i
);
    import cfg_port_pkg::*;

    initial begin
        if (POR_CYCLES < 1) $error("POR_CYCLES must be positive");
        if (SCLK_DIV < 2) $error("SCLK_DIV too small");
    end

    // ------------------------------------------------------------
    // power-on wait and command intake (clock domain)
    // ------------------------------------------------------------
    logic [31:0] por_cnt_ff;
    logic        por_done_ff;
    logic        req_tgl_ff;
    cmd_t        cmd_ff;
    logic        ack_s1_ff, ack_s2_ff, ack_s3_ff;
    logic        ack_tgl_ff;
    logic        pend;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            por_cnt_ff  <= 32'h0;
            por_done_ff <= 1'b0;
        end else if (!por_done_ff) begin
            por_cnt_ff  <= por_cnt_ff + 32'h1;
            por_done_ff <= (por_cnt_ff == 32'(POR_CYCLES - 1));
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ack_s1_ff <= 1'b0;
            ack_s2_ff <= 1'b0;
            ack_s3_ff <= 1'b0;
        end else begin
            ack_s1_ff <= ack_tgl_ff;
            ack_s2_ff <= ack_s1_ff;
            ack_s3_ff <= ack_s2_ff;
        end
    end

    assign pend      = req_tgl_ff != ack_s3_ff;
    assign cmd_ready = por_done_ff && !pend && (ack_s2_ff == ack_s3_ff);
    assign busy      = pend || !por_done_ff;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            req_tgl_ff <= 1'b0;
            cmd_ff     <= '0;
        end else if (cmd_valid && cmd_ready) begin
            cmd_ff     <= cmd;
            req_tgl_ff <= ~req_tgl_ff;
        end
    end

    // ------------------------------------------------------------
    // link engine (link_clock domain)
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        S_IDLE = 6'b000001,
        S_LOAD = 6'b000010,
        S_LOW  = 6'b000100,
        S_HIGH = 6'b001000,
        S_TURN = 6'b010000,
        S_END  = 6'b100000
    } st_t;

    st_t         st_ff;
    logic        req_s1_ff, req_s2_ff, req_s3_ff;
    logic        rd_ack_s1_ff, rd_ack_s2_ff, rd_ack_s3_ff;
    logic [7:0]  sh_ff;
    logic [2:0]  bit_ff;
    logic [4:0]  left_ff;
    logic        addr_ph_ff;
    logic [6:0]  cur_addr_ff;
    logic [3:0]  div_ff;
    logic        rd_mode;
    logic        div_tick;

    // write data crosses by a toggle handshake on each octet
    logic        wreq_tgl_ff, wack_s1_ff, wack_s2_ff, wack_s3_ff;
    logic [7:0]  wbuf_ff;
    logic        wtake_tgl_ff, wt_s1_ff, wt_s2_ff, wt_s3_ff;

    always_ff @(posedge link_clock or posedge link_rst) begin
        if (link_rst) begin
            req_s1_ff <= 1'b0;
            req_s2_ff <= 1'b0;
            req_s3_ff <= 1'b0;
            wack_s1_ff <= 1'b0;
            wack_s2_ff <= 1'b0;
            wack_s3_ff <= 1'b0;
        end else begin
            req_s1_ff <= req_tgl_ff;
            req_s2_ff <= req_s1_ff;
            req_s3_ff <= req_s2_ff;
            wack_s1_ff <= wreq_tgl_ff;
            wack_s2_ff <= wack_s1_ff;
            wack_s3_ff <= wack_s2_ff;
        end
    end

    assign rd_mode  = (cmd_ff.read == FLAG_READ);
    assign div_tick = (div_ff == 4'(SCLK_DIV - 1));

    always_ff @(posedge link_clock or posedge link_rst) begin
        if (link_rst)
            div_ff <= 4'h0;
        else if (st_ff == S_LOW || st_ff == S_HIGH)
            div_ff <= div_tick ? 4'h0 : div_ff + 4'h1;
        else
            div_ff <= 4'h0;
    end

    logic        wdata_avail;
    logic        push_rd;
    logic [7:0]  rd_shift_ff;
    logic        rd_tgl_ff;
    logic [14:0] rd_hold_ff;
    assign wdata_avail = (wack_s3_ff != wtake_tgl_ff)
                         && (wack_s2_ff == wack_s3_ff);

    // data pin filter: a new level counts once the last two stages agree
    logic        sdio_s1_ff, sdio_s2_ff, sdio_s3_ff, sdio_hold_ff;
    logic        sdio_in;
    assign sdio_in = (sdio_s2_ff == sdio_s3_ff) ? sdio_s3_ff : sdio_hold_ff;

    always_ff @(posedge link_clock or posedge link_rst) begin
        if (link_rst) begin
            sdio_s1_ff   <= 1'b0;
            sdio_s2_ff   <= 1'b0;
            sdio_s3_ff   <= 1'b0;
            sdio_hold_ff <= 1'b0;
        end else begin
            sdio_s1_ff   <= sdio_i;
            sdio_s2_ff   <= sdio_s1_ff;
            sdio_s3_ff   <= sdio_s2_ff;
            sdio_hold_ff <= sdio_in;
        end
    end

    always_ff @(posedge link_clock or posedge link_rst) begin
        if (link_rst) begin
            st_ff       <= S_IDLE;
            ack_tgl_ff  <= 1'b0;
            wtake_tgl_ff <= 1'b0;
            cs          <= 1'b0;
            sclk        <= 1'b0;
            sdio_o      <= 1'b0;
            sdio_oe     <= 1'b1;
            sh_ff       <= 8'h0;
            bit_ff      <= 3'h0;
            left_ff     <= 5'h0;
            addr_ph_ff  <= 1'b0;
            cur_addr_ff <= 7'h0;
            rd_shift_ff <= 8'h0;
            rd_tgl_ff   <= 1'b0;
            rd_hold_ff  <= 15'h0;
        end else begin
            case (st_ff)
                S_IDLE: begin
                    sdio_oe <= 1'b1;
                    if (req_s3_ff != ack_tgl_ff && req_s2_ff == req_s3_ff) begin
                        cs          <= 1'b1;
                        sh_ff       <= {cmd_ff.addr, cmd_ff.read};
                        cur_addr_ff <= cmd_ff.addr;
                        left_ff     <= cmd_ff.count;
                        addr_ph_ff  <= 1'b1;
                        bit_ff      <= 3'h7;
                        st_ff       <= S_LOW;
                    end
                end
                S_LOAD: begin
                    if (left_ff == 5'h0) begin
                        st_ff <= S_END;
                    end else if (rd_mode) begin
                        bit_ff <= 3'h7;
                        st_ff  <= S_LOW;
                    end else if (wdata_avail) begin
                        sh_ff        <= wbuf_ff;
                        wtake_tgl_ff <= ~wtake_tgl_ff;
                        bit_ff       <= 3'h7;
                        st_ff        <= S_LOW;
                    end
                end
                S_LOW: begin
                    // rising edge: host changes data, device drives reads
                    if (div_tick) begin
                        sclk <= 1'b1;
                        if (!(rd_mode && !addr_ph_ff))
                            sdio_o <= sh_ff[7];
                        st_ff <= S_HIGH;
                    end
                end
                S_HIGH: begin
                    if (div_tick) begin
                        sclk  <= 1'b0;
                        sh_ff <= {sh_ff[6:0], 1'b0};
                        if (rd_mode && !addr_ph_ff)
                            rd_shift_ff <= {rd_shift_ff[6:0], sdio_in};
                        if (bit_ff == 3'h0) begin
                            if (addr_ph_ff) begin
                                addr_ph_ff <= 1'b0;
                                if (rd_mode)
                                    sdio_oe <= 1'b0;
                                st_ff <= S_LOAD;
                            end else begin
                                left_ff <= left_ff - 5'h1;
                                cur_addr_ff <= cur_addr_ff + 7'h1;
                                if (rd_mode) begin
                                    rd_hold_ff <= {cur_addr_ff,
                                                   rd_shift_ff[6:0], sdio_in};
                                    rd_tgl_ff  <= ~rd_tgl_ff;
                                    st_ff      <= S_TURN;
                                end else begin
                                    st_ff <= S_LOAD;
                                end
                            end
                        end else begin
                            bit_ff <= bit_ff - 3'h1;
                            st_ff  <= S_LOW;
                        end
                    end
                end
                S_TURN: begin
                    // wait for the read side to take the octet
                    if (rd_ack_s3_ff == rd_tgl_ff && rd_ack_s2_ff == rd_tgl_ff)
                        st_ff <= S_LOAD;
                end
                S_END: begin
                    cs         <= 1'b0;
                    sdio_oe    <= 1'b1;
                    ack_tgl_ff <= ~ack_tgl_ff;
                    st_ff      <= S_IDLE;
                end
                default: st_ff <= S_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // write octet hand-over (clock -> link)
    // ------------------------------------------------------------
    assign wr_ready = (wreq_tgl_ff == wt_s3_ff) && (wt_s2_ff == wt_s3_ff);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wt_s1_ff <= 1'b0;
            wt_s2_ff <= 1'b0;
            wt_s3_ff <= 1'b0;
        end else begin
            wt_s1_ff <= wtake_tgl_ff;
            wt_s2_ff <= wt_s1_ff;
            wt_s3_ff <= wt_s2_ff;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wreq_tgl_ff <= 1'b0;
            wbuf_ff     <= 8'h0;
        end else if (wr_valid && wr_ready) begin
            wbuf_ff     <= wr_data;
            wreq_tgl_ff <= ~wreq_tgl_ff;
        end
    end

    // ------------------------------------------------------------
    // read octet hand-over (link -> clock) into a two-entry buffer
    // ------------------------------------------------------------
    logic     rd_s1_ff, rd_s2_ff, rd_s3_ff, rd_ack_ff;
    rd_word_t buf_ff [2];
    logic     wp_ff, rp_ff;
    logic [1:0] cnt_ff;
    logic     push;
    logic     pop;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_s1_ff <= 1'b0;
            rd_s2_ff <= 1'b0;
            rd_s3_ff <= 1'b0;
        end else begin
            rd_s1_ff <= rd_tgl_ff;
            rd_s2_ff <= rd_s1_ff;
            rd_s3_ff <= rd_s2_ff;
        end
    end

    always_ff @(posedge link_clock or posedge link_rst) begin
        if (link_rst) begin
            rd_ack_s1_ff <= 1'b0;
            rd_ack_s2_ff <= 1'b0;
            rd_ack_s3_ff <= 1'b0;
        end else begin
            rd_ack_s1_ff <= rd_ack_ff;
            rd_ack_s2_ff <= rd_ack_s1_ff;
            rd_ack_s3_ff <= rd_ack_s2_ff;
        end
    end

    // link stalls in S_TURN until a slot frees, so no octet is lost
    assign push = (rd_s3_ff != rd_ack_ff) && (rd_s2_ff == rd_s3_ff)
                  && (cnt_ff != 2'h2);
    assign pop  = rd_valid && rd_ready;
    assign rd_valid = (cnt_ff != 2'h0);
    assign rd_word  = buf_ff[rp_ff];

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_ack_ff <= 1'b0;
            wp_ff     <= 1'b0;
            rp_ff     <= 1'b0;
            cnt_ff    <= 2'h0;
            buf_ff[0] <= '0;
            buf_ff[1] <= '0;
        end else begin
            if (push) begin
                buf_ff[wp_ff] <= rd_hold_ff;
                wp_ff         <= ~wp_ff;
                rd_ack_ff     <= ~rd_ack_ff;
            end
            if (pop)
                rp_ff <= ~rp_ff;
            cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

// [cfg_dev_model.sv]
// behavioural model of the configuration device on the three-wire link
// assumes the bench resolves the shared data line into sdio
`timescale 1ns/10ps
module cfg_dev_model #(
    parameter int         DLY     = 2,
    parameter logic [7:0] TOP_VAL = 8'h3C
) (
    input  wire logic cs,
    input  wire logic sclk,
    input  wire logic sdio,
    output logic      dev_oe,
    output logic      dev_d,
    output logic [7:0] hdr
);
    logic [7:0] bank [23];
    logic [7:0] stage [23];
    logic [7:0] sh;
    logic [6:0] ptr;
    logic       rd;
    int         tot;
    int         ob;
    // ------------------------------------------------
    // shift, load and read-out
    // ------------------------------------------------
    initial begin
        foreach (bank[i]) bank[i] = 8'h00;
        bank[22] = TOP_VAL;
        {dev_oe, dev_d, hdr, sh, ptr, rd, tot, ob} = '0;
    end
    always @(posedge cs) begin
        tot = 0;
        ob = 0;
        rd = 1'b0;
        stage = bank;
    end
    // the model never drives sclk
    always @(negedge sclk) if (cs && !(rd && tot >= 8)) begin
        sh = {sh[6:0], sdio};
        tot++;
        if (tot == 8) begin
            hdr = sh;
            ptr = sh[7:1];
            rd = sh[0];
        end else if (tot % 8 == 0) begin
            if (ptr < 22) stage[ptr] = sh;
            ptr++;
        end
    end
    always @(posedge sclk) if (cs && rd && tot >= 8) begin
        dev_oe <= #DLY 1'b1;
        dev_d <= #DLY (ptr < 23) ? bank[ptr][7 - ob] : 1'b0;
        ob = (ob + 1) % 8;
        if (ob == 0) ptr++;
    end
    always @(negedge cs) begin
        dev_oe <= 1'b0;
        if (!rd) bank = stage;
    end
endmodule

// [cfg_port_host_assertions.sv]
// port checker for the three-wire configuration host
// bound into cfg_port_host by the testbench top
`timescale 1ns/10ps
module cfg_port_host_assertions #(
    parameter int POR_CYCLES = 4
) (
    input wire logic                   clock,
    input wire logic                   rst,
    input wire logic                   link_clock,
    input wire logic                   link_rst,
    input wire logic                   cmd_valid,
    input wire logic                   cmd_ready,
    input wire cfg_port_pkg::rd_word_t rd_word,
    input wire logic                   rd_valid,
    input wire logic                   rd_ready,
    input wire logic                   cs,
    input wire logic                   sclk,
    input wire logic                   sdio_o,
    input wire logic                   sdio_oe
);
    logic [15:0] por_ff;
    // ------------------------------------------------
    // properties
    // ------------------------------------------------
    always_ff @(posedge clock or posedge rst)
        if (rst) por_ff <= '0;
        else if (por_ff < POR_CYCLES) por_ff <= por_ff + 16'h1;
    property p_por;
        @(posedge clock) disable iff (rst)
        por_ff < POR_CYCLES |-> !cmd_ready;
    endproperty
    a_por: assert property (p_por)
        else $error("command taken during power-on wait");
    property p_start;
        @(posedge clock) disable iff (rst)
        cmd_valid && cmd_ready |-> ##[1:30] cs;
    endproperty
    a_start: assert property (p_start)
        else $error("select did not rise after command");
    property p_hold;
        @(posedge clock) disable iff (rst)
        rd_valid && !rd_ready |=> rd_valid && $stable(rd_word);
    endproperty
    a_hold: assert property (p_hold)
        else $error("read word dropped while stalled");
    property p_idle;
        @(posedge link_clock) disable iff (link_rst)
        !cs |-> sdio_oe && !sclk;
    endproperty
    a_idle: assert property (p_idle)
        else $error("link not idle outside a frame");
    property p_wr;
        @(posedge link_clock) disable iff (link_rst)
        cs && sdio_oe && $past(sclk) |-> $stable(sdio_o);
    endproperty
    a_wr: assert property (p_wr)
        else $error("data changed outside rising clock");
    property p_high;
        @(posedge link_clock) disable iff (link_rst)
        $rose(sclk) |-> sclk [*4] ##1 !sclk;
    endproperty
    a_high: assert property (p_high)
        else $error("serial clock high phase wrong");
    property p_low;
        @(posedge link_clock) disable iff (link_rst)
        $fell(sclk) |-> !sclk [*4];
    endproperty
    a_low: assert property (p_low)
        else $error("serial clock low phase short");
    property p_turn;
        @(posedge link_clock) disable iff (link_rst)
        $fell(sdio_oe) |-> cs && !sclk;
    endproperty
    a_turn: assert property (p_turn)
        else $error("data line released at wrong time");
    property p_back;
        @(posedge link_clock) disable iff (link_rst)
        $rose(sdio_oe) |-> !cs;
    endproperty
    a_back: assert property (p_back)
        else $error("data line retaken inside frame");
    property p_cs;
        @(posedge link_clock) disable iff (link_rst)
        $changed(cs) |-> !sclk;
    endproperty
    a_cs: assert property (p_cs)
        else $error("select moved with clock high");
endmodule

// [cfg_port_host_tb.sv]
// self-checking bench for the three-wire configuration host
// assumes cfg_dev_model on the link and the port checker bound in
`timescale 1ns/10ps
module cfg_port_host_tb;
    import cfg_port_pkg::*;
    logic       clock = 1'b0;
    logic       rst = 1'b1;
    logic       link_clock = 1'b0;
    logic       link_rst = 1'b1;
    cmd_t       cmd = '0;
    logic       cmd_valid = 1'b0;
    logic       wr_valid = 1'b0;
    logic       rd_ready = 1'b0;
    logic [7:0] wr_data = 8'h00;
    logic       cmd_ready, wr_ready, rd_valid, busy;
    logic       cs, sclk, sdio_o, sdio_oe, dev_oe, dev_d;
    logic       sdio_line;
    rd_word_t   rd_word;
    logic [7:0] hdr;
    logic [7:0] mirror [23];
    logic [14:0] exp_q [$];
    logic [31:0] lfsr = 32'hA0650F45;
    int         errors = 0;
    int         total_checks = 0;
    int         cycles = 0;
    // ------------------------------------------------
    // clocks, wiring, instances
    // ------------------------------------------------
    always #5 clock = ~clock;
    initial begin
        #1.3;
        forever #3 link_clock = ~link_clock;
    end
    // a released line shows the inverse of the device's last data bit (dev_d)
    assign sdio_line = sdio_oe ? sdio_o : dev_oe ? dev_d : ~dev_d;
    cfg_port_host #(.POR_CYCLES(4)) dut (.clock(clock), .rst(rst),
        .link_clock(link_clock), .link_rst(link_rst), .cmd(cmd),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .wr_data(wr_data),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_word(rd_word),
        .rd_valid(rd_valid), .rd_ready(rd_ready), .busy(busy), .cs(cs),
        .sclk(sclk), .sdio_o(sdio_o), .sdio_oe(sdio_oe), .sdio_i(sdio_line));
    cfg_dev_model #(.DLY(2), .TOP_VAL(8'h3C)) dev (.cs(cs), .sclk(sclk),
        .sdio(sdio_line), .dev_oe(dev_oe), .dev_d(dev_d), .hdr(hdr));
    // ------------------------------------------------
    // tasks
    // ------------------------------------------------
    function automatic logic [31:0] step(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic check(string n, logic [15:0] s, logic [15:0] e);
        total_checks++;
        if (s !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic xfer(logic rd, logic [6:0] a, int n);
        cmd = '{read: rd, addr: a, count: 5'(n)};
        cmd_valid = 1'b1;
        while (!cmd_ready) @(posedge clock) #1;
        @(posedge clock) #1;
        cmd_valid = 1'b0;
        for (int i = 0; i < n; i++) begin
            lfsr = step(lfsr);
            if (rd) begin
                exp_q.push_back({a + 7'(i),
                    (a + i < 23) ? mirror[a + i] : 8'h00});
            end else begin
                wr_data = lfsr[7:0];
                wr_valid = 1'b1;
                if (a + i < 22) mirror[a + i] = lfsr[7:0];
                while (!wr_ready) @(posedge clock) #1;
                @(posedge clock) #1;
                wr_valid = 1'b0;
                repeat (int'(lfsr[9:8]) + 1) @(posedge clock) #1;
            end
        end
        repeat (2) @(posedge clock) #1;
        while (busy) @(posedge clock) #1;
        while (exp_q.size() != 0) @(posedge clock) #1;
        check("header", {8'h00, hdr}, {8'h00, a, rd});
        $display("test done read %0d addr %0d count %0d", rd, a, n);
    endtask
    // ------------------------------------------------
    // monitor, stall driver, timeout
    // ------------------------------------------------
    always @(posedge clock)
        if (rd_valid === 1'b1 && rd_ready === 1'b1)
            check("rd_word", {1'b0, rd_word}, exp_q.size() != 0 ?
                {1'b0, exp_q.pop_front()} : 16'hXXXX);
    // long stalls let the two-entry buffer fill and refuse
    always @(posedge clock) begin
        #1;
        lfsr = step(lfsr);
        rd_ready = lfsr[5] && (cycles % 512 > 300);
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            summarize();
        end
    end
    // ------------------------------------------------
    // main sequence
    // ------------------------------------------------
    initial begin
        foreach (mirror[i]) mirror[i] = 8'h00;
        mirror[22] = 8'h3C;
        repeat (6) @(posedge clock);
        #1;
        rst = 1'b0;
        link_rst = 1'b0;
        check("busy", {15'h0, busy}, 16'h0001);
        xfer(1'b0, 7'h00, 22);
        xfer(1'b1, 7'h00, 23);
        xfer(1'b0, 7'h14, 2);
        xfer(1'b1, 7'h14, 4);
        xfer(1'b0, 7'h05, 1);
        xfer(1'b1, 7'h16, 1);
        xfer(1'b1, 7'h05, 1);
        xfer(1'b1, 7'h00, 23);
        summarize();
    end
endmodule
bind cfg_port_host cfg_port_host_assertions #(.POR_CYCLES(POR_CYCLES))
    u_chk (.clock(clock), .rst(rst), .link_clock(link_clock),
    .link_rst(link_rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .rd_word(rd_word), .rd_valid(rd_valid), .rd_ready(rd_ready), .cs(cs),
    .sclk(sclk), .sdio_o(sdio_o), .sdio_oe(sdio_oe));
